// ---- rtl/sfd_switch_diag.sv ----
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (RULE1) Reverse battery forces switch on
// (RULE2) Load dump keeps present switch state
// (RULE3) Latched fault holds off until hold low
// (RULE4) Auto-retry after fault clears and interval
// (RULE5) Fault shown until output nears supply
// (RULE6) Output stuck low keeps fault indefinitely
// (RULE7) Off-state comparator only diag high, switch low
// (RULE8) Open-load flag tracks comparator continuously
// (RULE9) Diag fall or enable rise clears
// (RULE10) Select low current, high temperature
// (RULE11) Current sense ratio is 1500
// (RULE12) Fault forces single fault level; code forces it only with select low, select high still shows temperature
// (RULE13) Report thermal, current limit, open load
// (RULE14) No open-load report while switch enabled
// (RULE15) Select high always shows temperature
// (RULE16) Sense high-impedance when diag low
// (RULE17) Leave fault when clear, hold low, timer
// (RULE18) Both low starts standby delay
// (RULE19) Current limit turns switch off immediately
// (RULE20) Timers configurable, sense as code plus flag
module sfd_switch_diag #(
    parameter int RETRY_LEN = sfd_pkg::RETRY_CYCLES,
    parameter int STANDBY_LEN = sfd_pkg::STANDBY_CYCLES,
    parameter int CUR_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog-side condition inputs (asynchronous)
    input wire logic reverse_battery_in,
    input wire logic over_temp_in,
    input wire logic current_limit_in,
    input wire logic open_load_cmp_in,
    input wire logic output_risen_in,
    input wire logic [CUR_W-1:0] load_current_in,
    // Switch and sense
    output logic switch_on,
    output logic open_load_probe_on,
    output sfd_pkg::sfd_src_t sense_src,
    output logic sense_hiz,
    output logic [CUR_W-1:0] sense_current,
    output logic standby
);
    import sfd_pkg::*;

    // ==========================================================
    // Input synchronisers (three stages, agree on last two)
    // ==========================================================
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] clean;
    assign raw_in = {reverse_battery_in, over_temp_in, current_limit_in,
                     open_load_cmp_in, output_risen_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Hold last agreed value while stages disagree
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1[gi] <= 1'b0;
                    s2[gi] <= 1'b0;
                    s3[gi] <= 1'b0;
                    clean[gi] <= 1'b0;
                end else begin
                    s1[gi] <= raw_in[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        clean[gi] <= s3[gi];
                    end
                end
            end
        end
    endgenerate

    wire rev_batt = clean[4];
    wire over_temp = clean[3];
    wire cur_limit = clean[2];
    wire ol_cmp = clean[1];
    wire out_risen = clean[0];

    // Load current word: three stages, taken once two and three
    // agree, so a word torn mid-change never reaches the sense
    logic [CUR_W-1:0] cur_s1;
    logic [CUR_W-1:0] cur_s2;
    logic [CUR_W-1:0] cur_s3;
    logic [CUR_W-1:0] cur_clean;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_s1 <= '0;
            cur_s2 <= '0;
            cur_s3 <= '0;
            cur_clean <= '0;
        end else begin
            cur_s1 <= load_current_in;
            cur_s2 <= cur_s1;
            cur_s3 <= cur_s2;
            if (cur_s2 == cur_s3) begin
                cur_clean <= cur_s3;
            end
        end
    end

    // ==========================================================
    // Control register and AXI4-Lite slave
    // ==========================================================
    logic [31:0] ctrl;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire sw_en = ctrl[CTRL_SW_EN_BIT];
    wire diag_enable_in = ctrl[CTRL_DIAG_EN_BIT];
    wire measure_select_in = ctrl[CTRL_SEL_BIT];
    wire fault_hold = ctrl[CTRL_HOLD_BIT];

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_hit = (aw_addr == CTRL_OFFSET);
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address and data accepted in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl <= CTRL_RESET;
        end else begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                if (wr_hit) begin
                    ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_000F;
                end
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                s_axi_bvalid <= 1'b1;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Fault state machine
    // ==========================================================
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_FAULT,
        ST_RETRY
    } sfd_state_t;
    sfd_state_t state;
    sfd_state_t next_state;

    sfd_timer_if retry_tif ();
    sfd_timer_if stby_tif ();
    sfd_timer #(.LENGTH(RETRY_LEN)) u_retry (
        .aclk(aclk),
        .aresetn(aresetn),
        .tif(retry_tif)
    );
    sfd_timer #(.LENGTH(STANDBY_LEN)) u_standby (
        .aclk(aclk),
        .aresetn(aresetn),
        .tif(stby_tif)
    );

    wire shutdown_cause = over_temp || cur_limit;
    assign retry_tif.run = (state == ST_FAULT); // RULE20
    assign stby_tif.run = !sw_en && !diag_enable_in; // RULE18 RULE20
    wire may_leave = !shutdown_cause && !fault_hold
                     && retry_tif.expired; // RULE3 RULE4 RULE17

    // Next state; current limit wins over every other path while the switch is enabled
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                if (shutdown_cause && sw_en) begin
                    next_state = ST_FAULT;
                end else if (sw_en || diag_enable_in) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (shutdown_cause && sw_en) begin
                    next_state = ST_FAULT; // RULE19
                end else if (stby_tif.expired && stby_tif.run) begin
                    next_state = ST_STANDBY; // RULE18
                end
            end
            ST_FAULT: begin
                if (may_leave) begin
                    next_state = sw_en ? ST_RETRY : ST_ACTIVE; // RULE17
                end
            end
            ST_RETRY: begin
                if (shutdown_cause) begin
                    next_state = ST_FAULT;
                end else if (out_risen || !sw_en) begin
                    next_state = ST_ACTIVE; // RULE5
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Switch drive
    // ==========================================================
    // Load dump is not an input here: nothing but control, reverse battery and the
    // shutdown causes moves the switch, so its state is kept
    wire next_switch = rev_batt // RULE1
        || (sw_en && !shutdown_cause
            && (state == ST_ACTIVE || state == ST_RETRY
                || (state == ST_STANDBY))); // RULE2 RULE19

    // ==========================================================
    // Open-load / short-to-battery indication
    // ==========================================================
    logic diag_q;
    logic en_q;
    logic ol_flag;
    wire diag_fall = diag_q && !diag_enable_in;
    wire en_rise = !en_q && sw_en;
    wire ol_window = diag_enable_in && !sw_en; // RULE7 RULE14

    // Live comparator result; edges force a clear that cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_q <= 1'b0;
            en_q <= 1'b0;
            ol_flag <= 1'b0;
        end else begin
            diag_q <= diag_enable_in;
            en_q <= sw_en;
            if (diag_fall || en_rise) begin
                ol_flag <= 1'b0; // RULE9
            end else begin
                ol_flag <= ol_window && ol_cmp; // RULE7 RULE8
            end
        end
    end

    // ==========================================================
    // Sense mux
    // ==========================================================
    // Fault covers shutdown-and-waiting, retry before output rises
    // (stuck forever if shorted low) and open load
    wire shut_fault = (state == ST_FAULT) || (state == ST_RETRY); // RULE5 RULE6
    wire any_fault = shut_fault || ol_flag; // RULE13
    wire sfd_src_t next_src = measure_select_in ? SFD_SRC_TEMP // RULE15
        : (any_fault ? SFD_SRC_FAULT : SFD_SRC_CURRENT); // RULE10 RULE12
    wire [CUR_W-1:0] scaled = CUR_W'(cur_clean / CURRENT_SENSE_RATIO); // RULE11

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_on <= 1'b0;
            open_load_probe_on <= 1'b0;
            sense_src <= SFD_SRC_CURRENT;
            sense_hiz <= 1'b1;
            sense_current <= '0;
            standby <= 1'b1;
        end else begin
            switch_on <= next_switch;
            open_load_probe_on <= ol_window; // RULE7
            sense_src <= next_src;
            sense_hiz <= !diag_enable_in; // RULE16
            sense_current <= scaled;
            standby <= (next_state == ST_STANDBY);
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    wire [31:0] status_word = {24'h00_0000, out_risen, rev_batt,
        ol_flag, cur_limit, over_temp, state == ST_RETRY,
        state == ST_FAULT, state == ST_STANDBY};
    wire [31:0] sense_word = {12'h000, 2'b00, sense_hiz,
        sense_src == SFD_SRC_FAULT, 16'(sense_current)};
    wire rd_ok = (s_axi_araddr == CTRL_OFFSET)
        || (s_axi_araddr == STATUS_OFFSET)
        || (s_axi_araddr == SENSE_OFFSET);
    wire [31:0] rd_word = (s_axi_araddr == CTRL_OFFSET) ? ctrl
        : (s_axi_araddr == STATUS_OFFSET) ? status_word
        : (s_axi_araddr == SENSE_OFFSET) ? sense_word : 32'h0000_0000;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : sfd_switch_diag
`default_nettype wire

// ---- rtl/sfd_pkg.sv ----
`default_nettype none
package sfd_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int RETRY_INTERVAL_US = 1000;
    localparam int RETRY_CYCLES = RETRY_INTERVAL_US * 1000 / CLK_PERIOD_NS;
    localparam int STANDBY_DELAY_US = 1000;
    localparam int STANDBY_CYCLES = STANDBY_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int CURRENT_SENSE_RATIO = 1500;
    localparam int TIMER_W = 24;

    // ==========================================================
    // AXI4-Lite register map
    // ==========================================================
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SENSE_OFFSET = 8'h08;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_SW_EN_BIT = 0;
    localparam int CTRL_DIAG_EN_BIT = 1;
    localparam int CTRL_SEL_BIT = 2;
    localparam int CTRL_HOLD_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Sense output source
    typedef enum logic [1:0] {
        SFD_SRC_CURRENT,
        SFD_SRC_TEMP,
        SFD_SRC_FAULT
    } sfd_src_t;
endpackage : sfd_pkg
`default_nettype wire

// ---- rtl/sfd_timer_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Start/expiry handshake between controller and delay timers
interface sfd_timer_if;
    logic run;
    logic expired;
    modport ctrl (output run, input expired);
    modport timer (input run, output expired);
endinterface : sfd_timer_if
`default_nettype wire

// ---- rtl/sfd_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Delay counter: counts while run, expired after LENGTH cycles
// ==========================================================
module sfd_timer #(
    parameter int LENGTH = 100
) (
    input wire logic aclk,
    input wire logic aresetn,
    sfd_timer_if.timer tif
);
    import sfd_pkg::*;
    logic [TIMER_W-1:0] count;
    localparam logic [TIMER_W-1:0] LAST = TIMER_W'(LENGTH - 1);

    // Restart whenever run drops, so each start sees a full delay
    always_ff @(posedge aclk) begin
        if (!aresetn || !tif.run) begin
            count <= '0;
            tif.expired <= 1'b0;
        end else if (count >= LAST) begin
            tif.expired <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule : sfd_timer
`default_nettype wire

// ---- verification/sfd_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Port checker
// ========================================
module sfd_chk #(
    parameter int RETRY_LEN = 20,
    parameter int STANDBY_LEN = 20,
    parameter int CUR_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic reverse_battery_in,
    input wire logic over_temp_in,
    input wire logic current_limit_in,
    input wire logic open_load_cmp_in,
    input wire logic [CUR_W-1:0] load_current_in,
    input wire logic switch_on,
    input wire logic open_load_probe_on,
    input wire sfd_pkg::sfd_src_t sense_src,
    input wire logic sense_hiz,
    input wire logic [CUR_W-1:0] sense_current,
    input wire logic standby
);
    import sfd_pkg::*;
    logic [7:0] a_q;
    logic [3:0] d_q;
    logic [3:0] ctl;
    logic [7:0] age;
    wire ol_ok;
    // Quiet open-load window, long after any retry has run out
    assign ol_ok = ctl == 4'h2 && age > RETRY_LEN + 40 && !over_temp_in
        && !reverse_battery_in;
    // Shadow of the control word; commits late, so age gives slack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= 4'h0;
            age <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wstrb[0] ?
                s_axi_wdata[3:0] : ctl;
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY
                && a_q == CTRL_OFFSET && d_q != ctl) begin
                ctl <= d_q;
                age <= 8'h00;
            end else if (age != 8'hFF) begin
                age <= age + 8'h01;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rev_force: assert property (
        reverse_battery_in[*8] |-> switch_on)
        else $error("switch off under reverse battery");
    chk_cl_off: assert property (
        (current_limit_in && !reverse_battery_in)[*5] |=> !switch_on)
        else $error("switch on during current limit");
    chk_ot_off: assert property (
        (over_temp_in && !reverse_battery_in)[*8] |-> !switch_on)
        else $error("switch on during overtemperature");
    chk_latch_hold: assert property (
        ctl[3] && age > 2 && !switch_on && !reverse_battery_in |=> !switch_on)
        else $error("switch left latched fault");
    chk_hiz_diag: assert property (age > 2 |-> sense_hiz == !ctl[1])
        else $error("sense impedance wrong");
    chk_temp_sel: assert property (
        age > 2 && ctl[2:1] == 2'b11 |-> sense_src == SFD_SRC_TEMP)
        else $error("select high not temperature");
    chk_probe_gate: assert property (
        age > 2 |-> open_load_probe_on == (ctl[1] && !ctl[0]))
        else $error("probe gating wrong");
    chk_ol_set: assert property (
        (ol_ok && open_load_cmp_in)[*8] |-> sense_src == SFD_SRC_FAULT)
        else $error("open load not shown");
    chk_ol_clear: assert property (
        (ol_ok && !open_load_cmp_in)[*8] |-> sense_src == SFD_SRC_CURRENT)
        else $error("open load not cleared");
    chk_sense_ratio: assert property (
        $stable(load_current_in)[*5] |->
        sense_current == CUR_W'(load_current_in / 1500))
        else $error("sense current ratio wrong");
    chk_standby_dly: assert property (
        age > STANDBY_LEN + 4 && !reverse_battery_in |->
        standby == (ctl[1:0] == 2'b00))
        else $error("standby state wrong");
    cov_fault_on: cover property (sense_src == SFD_SRC_FAULT && switch_on);
    cov_retry: cover property ($rose(switch_on) && ctl[0]);
    cov_standby: cover property ($rose(standby));
endmodule : sfd_chk
bind sfd_switch_diag sfd_chk #(.RETRY_LEN(RETRY_LEN),
    .STANDBY_LEN(STANDBY_LEN), .CUR_W(CUR_W)) chk_u (.*);
`default_nettype wire

// ---- verification/sfd_load_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Load side: 0 healthy, 1 short, 2 open, 3 held low
// ========================================
module sfd_load_model #(
    parameter int RISE = 6
) (
    input wire logic aclk,
    input wire logic switch_on,
    input wire logic [1:0] mode,
    output logic current_limit_in,
    output logic output_risen_in,
    output logic open_load_cmp_in
);
    int on_cnt = 0;
    // Output needs a few cycles to climb; a short never gets there
    always @(posedge aclk) begin
        on_cnt <= switch_on ? on_cnt + 1 : 0;
        current_limit_in <= switch_on && mode == 2'd1;
        output_risen_in <= switch_on && on_cnt >= RISE && !mode[0];
        open_load_cmp_in <= !switch_on && mode == 2'd2;
    end
endmodule : sfd_load_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb;
    import sfd_pkg::*;
    localparam int RL = 20;
    localparam int SL = 20;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reverse_battery_in = 1'b0, over_temp_in = 1'b0;
    logic current_limit_in, output_risen_in, open_load_cmp_in;
    logic [15:0] load_current_in = 16'h0, sense_current;
    logic [1:0] mode = 2'd0;
    logic switch_on, open_load_probe_on, sense_hiz, standby;
    sfd_src_t sense_src;
    int n_mismatch = 0;
    int checks_done = 0;
    sfd_switch_diag #(.RETRY_LEN(RL), .STANDBY_LEN(SL)) dut_u (.*);
    sfd_load_model load_u (.*);
    always #5 aclk = ~aclk;
    // ========================================
    // Bus and helper tasks
    // ========================================
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(s_axi_bvalid && s_axi_bready)) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(s_axi_rvalid && s_axi_rready)) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wctl(input logic [3:0] c);
        logic [1:0] r;
        wr(CTRL_OFFSET, {28'h0, c}, r);
    endtask : wctl
    // Integer divide, the fraction is dropped
    function automatic logic [15:0] exp_ratio(input logic [15:0] c);
        return c / 16'd1500;
    endfunction : exp_ratio
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard, far beyond the several hundred cycles needed
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end
    // ========================================
    // Scenarios
    // ========================================
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] lc;
        int seed;
        seed = 30901;
        cyc(2);
        aresetn <= 1'b1;
        cyc(2);
        rd(CTRL_OFFSET, d, r);
        `CHK("ctrl rst", CTRL_RESET, d)
        rd(8'h0C, d, r);
        `CHK("unmapped rd", RESP_SLVERR, r)
        wr(8'h10, 32'hF, r);
        `CHK("unmapped wr", RESP_SLVERR, r)
        rd(SENSE_OFFSET, d, r);
        `CHK("hiz bit", 1'b1, d[17])
        // Current sense, corners first then random
        wctl(4'h3);
        for (int i = 0; i < 8; i++) begin
            lc = i == 0 ? 16'd1499 : i == 1 ? 16'd1500 :
                i == 2 ? 16'hFFFF : 16'($random(seed));
            load_current_in <= lc;
            cyc(6);
            `CHK("ratio", exp_ratio(lc), sense_current)
            `CHK("src cur", SFD_SRC_CURRENT, sense_src)
        end
        `CHK("hiz off", 1'b0, sense_hiz)
        // Overtemperature under both selections
        wctl(4'h7);
        cyc(4);
        `CHK("src temp", SFD_SRC_TEMP, sense_src)
        over_temp_in <= 1'b1;
        cyc(8);
        `CHK("ot off", 1'b0, switch_on)
        `CHK("ot sel", SFD_SRC_TEMP, sense_src)
        wctl(4'h3);
        cyc(4);
        `CHK("ot fault", SFD_SRC_FAULT, sense_src)
        over_temp_in <= 1'b0;
        cyc(RL + 40);
        `CHK("ot retry", 1'b1, switch_on)
        `CHK("ot clear", SFD_SRC_CURRENT, sense_src)
        // Latched current limit, then released
        wctl(4'hB);
        mode <= 2'd1;
        cyc(10);
        `CHK("cl off", 1'b0, switch_on)
        `CHK("cl fault", SFD_SRC_FAULT, sense_src)
        mode <= 2'd0;
        cyc(RL + 30);
        `CHK("latched", 1'b0, switch_on)
        rd(STATUS_OFFSET, d, r);
        `CHK("st fault", 1'b1, d[1])
        wctl(4'h3);
        cyc(4);
        `CHK("retry on", 1'b1, switch_on)
        `CHK("retry flag", SFD_SRC_FAULT, sense_src)
        cyc(20);
        `CHK("risen", SFD_SRC_CURRENT, sense_src)
        // Auto-retry into an output that never rises
        mode <= 2'd1;
        cyc(RL + 10);
        mode <= 2'd3;
        cyc(4 * RL + 40);
        `CHK("stuck on", 1'b1, switch_on)
        `CHK("stuck flag", SFD_SRC_FAULT, sense_src)
        mode <= 2'd0;
        cyc(20);
        `CHK("stuck gone", SFD_SRC_CURRENT, sense_src)
        // Off-state open load, tracking and enable-edge clear
        wctl(4'h2);
        mode <= 2'd2;
        cyc(RL + 50);
        `CHK("probe", 1'b1, open_load_probe_on)
        `CHK("ol flag", SFD_SRC_FAULT, sense_src)
        mode <= 2'd0;
        cyc(12);
        `CHK("ol track", SFD_SRC_CURRENT, sense_src)
        mode <= 2'd2;
        cyc(12);
        wctl(4'h3);
        cyc(3);
        `CHK("ol en clr", SFD_SRC_CURRENT, sense_src)
        `CHK("ol on", 1'b0, open_load_probe_on)
        mode <= 2'd0;
        // Standby, then reverse battery with the switch disabled
        wctl(4'h0);
        cyc(SL + 10);
        `CHK("standby", 1'b1, standby)
        reverse_battery_in <= 1'b1;
        cyc(10);
        `CHK("rev on", 1'b1, switch_on)
        reverse_battery_in <= 1'b0;
        cyc(10);
        `CHK("rev off", 1'b0, switch_on)
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
